// File: sbs_port.sv
`timescale 1ns/10ps
// Notes on behaviour
// - All inputs sampled on clock rise except reset, output enable, mode, sleep, order.
// - Word address captured only when all selects active and a strobe asserted.
// - Data lanes driven only when selected, reading and output enable low.
// - Master select looked at only on edges with an address strobe low.
// - Master select inactive blocks the processor strobe.
// - Second select active high, third active low, sampled with a start.
// - Processor strobe low loads an address or deselects.
// - Controller strobe low loads an address or deselects.
// - Burst step strobe low continues the burst to the next word.
// - All-bytes write low writes every bit of the word.
// - Per-byte selects count only while byte gate sampled low.
// - Byte gate low: any select low is write, none low is read.
// - Order select high gives exclusive-or order, low gives linear order.
// - Order select defaults high, giving interleaved order when floating.
// - Mode select low gives one output register, high gives two stages.
// - Sleep request holds everything still with data retained, outputs off.
// - Burst address advances when step low and both strobes high.
// - Pipelined read data appears after the edge following address capture.
module sbs_port (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  // Address and strobes
  input  wire logic [sbs_pkg::ADDR_W-1:0] word_address,
  input  wire logic                       cpu_address_strobe_n,
  input  wire logic                       ctrl_address_strobe_n,
  input  wire logic                       burst_step_strobe_n,
  // Chip selects
  input  wire logic                       master_chip_select_n,
  input  wire logic                       chip_select_high,
  input  wire logic                       chip_select_low_n,
  // Write control
  input  wire logic                       all_bytes_write_n,
  input  wire logic                       byte_lane_write_gate_n,
  input  wire logic [3:0]                 per_byte_write_select_n,
  // Slow pins
  input  wire logic                       output_enable_n,
  input  wire logic                       single_register_path_select_n,
  input  wire logic                       count_order_select,
  input  wire logic                       sleep_request,
  // Data lanes
  input  wire logic [sbs_pkg::DATA_W-1:0] dq_in,
  output logic      [sbs_pkg::DATA_W-1:0] dq_out,
  output logic                            dq_oe,
  // Status
  output logic                            sleep_active
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [sbs_pkg::SYNC_N-1:0]  meta_ff;
  logic [sbs_pkg::SYNC_N-1:0]  sync_ff;
  sbs_pkg::sbs_state_e         state_ff;
  logic [sbs_pkg::ADDR_W-1:0]  addr_ff;
  logic [1:0]                  start_lo_ff;
  logic [1:0]                  count_ff;
  logic [sbs_pkg::DATA_W-1:0]  stage_ff;
  logic                        stage_vld_ff;
  logic [sbs_pkg::DATA_W-1:0]  dq_out_ff;
  logic                        dq_oe_ff;
  logic                        sleep_ff;
  logic                        oe_sync_n;
  logic                        pipelined;
  logic                        asleep;
  logic                        interleave;
  logic                        awake;
  logic                        cpu_start;
  logic                        ctrl_start;
  logic                        any_start;
  logic                        sel_hit;
  logic                        load;
  logic                        cont;
  logic                        step;
  logic [1:0]                  nxt_count;
  logic [1:0]                  next_lo;
  logic [sbs_pkg::ADDR_W-1:0]  next_addr;
  logic [sbs_pkg::ADDR_W-1:0]  acc_addr;
  logic [3:0]                  lane_write;
  logic                        is_write;
  logic                        wr_go;
  logic                        rd_go;
  logic [sbs_pkg::DATA_W-1:0]  rd_word;

  // ----------------------------------------------------------------
  // Slow pin synchronisers
  // ----------------------------------------------------------------
  // order select resets high
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_ff <= sbs_pkg::SYNC_RST;
      sync_ff <= sbs_pkg::SYNC_RST;
    end else begin
      meta_ff <= {count_order_select, sleep_request,
                  single_register_path_select_n, output_enable_n};
      sync_ff <= meta_ff;
    end
  end

  // asynchronous and static pins used only after sync
  assign oe_sync_n  = sync_ff[sbs_pkg::SYNC_OE_N];
  assign pipelined  = sync_ff[sbs_pkg::SYNC_PIPE];
  assign asleep     = sync_ff[sbs_pkg::SYNC_SLEEP];
  assign interleave = sync_ff[sbs_pkg::SYNC_ORDER];
  assign awake      = !asleep;

  // ----------------------------------------------------------------
  // Start and continue decode
  // ----------------------------------------------------------------
  // processor strobe blocked by master select
  assign cpu_start  = !cpu_address_strobe_n && !master_chip_select_n;
  // controller strobe start, processor start wins
  assign ctrl_start = !ctrl_address_strobe_n && !cpu_start;
  // selects looked at only with a strobe
  assign any_start  = cpu_start || ctrl_start;
  assign sel_hit    = !master_chip_select_n && chip_select_high && !chip_select_low_n;
  assign load       = awake && any_start && sel_hit;
  // both strobes high continues a burst
  assign cont       = awake && !any_start && (state_ff != sbs_pkg::ST_IDLE);
  assign step       = cont && !burst_step_strobe_n;

  // ----------------------------------------------------------------
  // Burst address and write decode
  // ----------------------------------------------------------------
  assign nxt_count = count_ff + sbs_pkg::COUNT_STEP;

  // Low bits of the next burst word
  sbs_burst_seq u_burst (
    .start_lo   (start_lo_ff),
    .count      (nxt_count),
    .interleave (interleave),
    .addr_lo    (next_lo)
  );

  // only the two low bits move
  assign next_addr = {addr_ff[sbs_pkg::ADDR_W-1:2], next_lo};
  assign acc_addr  = load ? word_address : (step ? next_addr : addr_ff);

  // Lane write enables
  sbs_write_decode u_wdec (
    .all_bytes_write_n       (all_bytes_write_n),
    .byte_lane_write_gate_n  (byte_lane_write_gate_n),
    .per_byte_write_select_n (per_byte_write_select_n),
    .lane_write              (lane_write),
    .is_write                (is_write)
  );

  // Writes ignored on a processor start edge
  assign wr_go = is_write && ((load && ctrl_start) || cont);
  assign rd_go = !is_write ? (load || cont) : (load && cpu_start);

  // ----------------------------------------------------------------
  // Cycle state and address
  // ----------------------------------------------------------------
  // strobe loads or deselects
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff    <= sbs_pkg::ST_IDLE;
      addr_ff     <= sbs_pkg::ADDR_RST;
      start_lo_ff <= sbs_pkg::COUNT_RST;
      count_ff    <= sbs_pkg::COUNT_RST;
    end else if (awake && any_start) begin
      if (sel_hit) begin
        state_ff    <= (ctrl_start && is_write) ? sbs_pkg::ST_WRITE : sbs_pkg::ST_READ;
        addr_ff     <= word_address;
        start_lo_ff <= word_address[1:0];
        count_ff    <= sbs_pkg::COUNT_RST;
      end else begin
        state_ff <= sbs_pkg::ST_IDLE;
      end
    end else if (cont) begin
      state_ff <= is_write ? sbs_pkg::ST_WRITE : sbs_pkg::ST_READ;
      if (step) begin
        addr_ff  <= next_addr;
        count_ff <= nxt_count;
      end
    end
  end

  // ----------------------------------------------------------------
  // Storage, one array per byte lane
  // ----------------------------------------------------------------
  for (genvar g = 0; g < sbs_pkg::LANES; g++) begin : g_lane
    logic [sbs_pkg::LANE_W-1:0] lane_mem [0:sbs_pkg::DEPTH-1];

    // array never cleared, retained in sleep
    always_ff @(posedge core_clk) begin
      if (wr_go && lane_write[g]) begin
        lane_mem[acc_addr] <= dq_in[g*sbs_pkg::LANE_W +: sbs_pkg::LANE_W];
      end
    end

    assign rd_word[g*sbs_pkg::LANE_W +: sbs_pkg::LANE_W] = lane_mem[acc_addr];
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // first output stage
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stage_ff     <= sbs_pkg::DATA_RST;
      stage_vld_ff <= 1'b0;
    end else begin
      stage_vld_ff <= rd_go;
      if (rd_go) begin
        stage_ff <= rd_word;
      end
    end
  end

  // one or two registers to the pins
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dq_out_ff <= sbs_pkg::DATA_RST;
    end else if (pipelined) begin
      dq_out_ff <= stage_ff;
    end else if (rd_go) begin
      dq_out_ff <= rd_word;
    end
  end

  // drive only for reads with enable low
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dq_oe_ff <= 1'b0;
    end else begin
      dq_oe_ff <= (pipelined ? stage_vld_ff : rd_go) && !oe_sync_n && awake && !wr_go;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sleep_ff <= sbs_pkg::SLEEP_RST;
    end else begin
      sleep_ff <= asleep;
    end
  end

  assign dq_out       = dq_out_ff;
  assign dq_oe        = dq_oe_ff;
  assign sleep_active = sleep_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  addr_capture_a: assert property (@(posedge core_clk) disable iff (rst)
    load |=> addr_ff == $past(word_address))
    else $error("address not captured on start");

  cpu_blocked_a: assert property (@(posedge core_clk) disable iff (rst)
    (awake && !cpu_address_strobe_n && master_chip_select_n && ctrl_address_strobe_n
     && state_ff == sbs_pkg::ST_IDLE) |=> state_ff == sbs_pkg::ST_IDLE)
    else $error("blocked processor strobe started a cycle");

  deselect_a: assert property (@(posedge core_clk) disable iff (rst)
    (awake && any_start && !sel_hit) |=> state_ff == sbs_pkg::ST_IDLE && !stage_vld_ff
      && ($past(pipelined) || !dq_oe_ff))
    else $error("start with inactive select did not deselect");

  linear_order_a: assert property (@(posedge core_clk) disable iff (rst)
    (step && !interleave) |=> addr_ff[1:0] == 2'($past(addr_ff[1:0]) + 2'h1))
    else $error("linear burst order wrong");

  xor_order_a: assert property (@(posedge core_clk) disable iff (rst)
    (step && interleave) |=> ((addr_ff[1:0] ^ start_lo_ff) == count_ff)
      && addr_ff[15:2] == $past(addr_ff[15:2]))
    else $error("interleaved burst order wrong");

  all_bytes_a: assert property (@(posedge core_clk) disable iff (rst)
    !all_bytes_write_n |-> lane_write == 4'hf)
    else $error("global write missed a lane");

  byte_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    (all_bytes_write_n && byte_lane_write_gate_n) |-> !wr_go && lane_write == 4'h0)
    else $error("byte selects acted without gate");

  pipe_latency_a: assert property (@(posedge core_clk) disable iff (rst)
    (rd_go && pipelined) ##1 pipelined |=> dq_out_ff == $past(rd_word, 2))
    else $error("pipelined data not two edges after address");

  flow_latency_a: assert property (@(posedge core_clk) disable iff (rst)
    (rd_go && !pipelined) |=> dq_out_ff == $past(rd_word))
    else $error("flow-through data not one edge after address");

  oe_gating_a: assert property (@(posedge core_clk) disable iff (rst)
    dq_oe_ff |-> $past(!oe_sync_n) && $past(!wr_go) && $past(awake))
    else $error("lanes driven outside a read");

  sleep_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    asleep |=> $stable(addr_ff) && $stable(state_ff) && !dq_oe_ff)
    else $error("state moved during sleep");

endmodule

// File: sbs_pkg.sv
package sbs_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W  = 16;
  localparam int DEPTH   = 65536;
  localparam int LANES   = 4;
  localparam int LANE_W  = 9;
  localparam int DATA_W  = LANES * LANE_W;
  localparam int BURST_W = 2;

  // ----------------------------------------------------------------
  // Values after reset, and the burst count step
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0]  ADDR_RST   = 16'h0000;
  localparam logic [BURST_W-1:0] COUNT_RST  = 2'h0;
  localparam logic [DATA_W-1:0]  DATA_RST   = 36'h0_0000_0000;
  localparam logic               OE_N_RST   = 1'h1;
  localparam logic               PIPE_RST   = 1'h1;
  localparam logic               SLEEP_RST  = 1'h0;
  localparam logic               ORDER_RST  = 1'h1;
  localparam logic [BURST_W-1:0] COUNT_STEP = 2'h1;

  // ----------------------------------------------------------------
  // Positions of the slow pins in the synchroniser vector
  // ----------------------------------------------------------------
  localparam int SYNC_N     = 4;
  localparam int SYNC_OE_N  = 0;
  localparam int SYNC_PIPE  = 1;
  localparam int SYNC_SLEEP = 2;
  localparam int SYNC_ORDER = 3;
  localparam logic [SYNC_N-1:0] SYNC_RST = {ORDER_RST, SLEEP_RST, PIPE_RST, OE_N_RST};

  // ----------------------------------------------------------------
  // Cycle state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } sbs_state_e;

endpackage

// File: sbs_write_decode.sv
`timescale 1ns/10ps
module sbs_write_decode (
  // Write strobes
  input  wire logic       all_bytes_write_n,
  input  wire logic       byte_lane_write_gate_n,
  input  wire logic [3:0] per_byte_write_select_n,
  // Decoded lanes
  output logic      [3:0] lane_write,
  output logic            is_write
);

  // Global write beats the byte path
  always_comb begin
    if (!all_bytes_write_n) begin
      lane_write = 4'hf;
    end else if (!byte_lane_write_gate_n) begin
      lane_write = ~per_byte_write_select_n;
    end else begin
      lane_write = 4'h0;
    end
  end

  assign is_write = |lane_write;

endmodule

// File: sbs_burst_seq.sv
`timescale 1ns/10ps
module sbs_burst_seq (
  // Burst position
  input  wire logic [1:0] start_lo,
  input  wire logic [1:0] count,
  input  wire logic       interleave,
  // Low address bits
  output logic      [1:0] addr_lo
);

  assign addr_lo = interleave ? (start_lo ^ count) : 2'(start_lo + count);

endmodule

// File: sbs_master_model.sv
`timescale 1ns/10ps
module sbs_master_model (
  // Clock
  input  wire logic                       core_clk,
  // Address and strobes
  output logic      [sbs_pkg::ADDR_W-1:0] word_address,
  output logic                            cpu_address_strobe_n,
  output logic                            ctrl_address_strobe_n,
  output logic                            burst_step_strobe_n,
  // Chip selects
  output logic                            master_chip_select_n,
  output logic                            chip_select_high,
  output logic                            chip_select_low_n,
  // Write control and data
  output logic                            all_bytes_write_n,
  output logic                            byte_lane_write_gate_n,
  output logic      [3:0]                 per_byte_write_select_n,
  output logic      [sbs_pkg::DATA_W-1:0] dq_in
);
  // Selects held until changed
  task automatic sel(input logic m_n, input logic h, input logic l_n);
    master_chip_select_n = m_n;
    chip_select_high = h;
    chip_select_low_n = l_n;
  endtask

  // One bus cycle, launched after an edge, held to the next edge
  task automatic cyc(input logic cpu_n, input logic ctl_n, input logic stp_n,
                     input logic abw_n, input logic gate_n, input logic [3:0] bs_n,
                     input logic [15:0] addr, input logic [35:0] data);
    logic wr;
    wr = !abw_n || (!gate_n && bs_n != 4'hf);
    // processor strobe high on controller start
    cpu_address_strobe_n = cpu_n | ~ctl_n;
    ctrl_address_strobe_n = ctl_n;
    burst_step_strobe_n = stp_n;
    all_bytes_write_n = abw_n;
    byte_lane_write_gate_n = gate_n;
    per_byte_write_select_n = bs_n;
    // Unused lines carry no stale value
    word_address = (cpu_n && ctl_n) ? ~word_address : addr;
    dq_in = wr ? data : ~dq_in;
    @(posedge core_clk);
    #1;
  endtask

  // Quiet bus at time zero
  initial begin
    word_address = 16'h0000;
    dq_in = 36'h0_0000_0000;
    sel(1'b0, 1'b1, 1'b0);
    cpu_address_strobe_n = 1'b1;
    ctrl_address_strobe_n = 1'b1;
    burst_step_strobe_n = 1'b1;
    all_bytes_write_n = 1'b1;
    byte_lane_write_gate_n = 1'b1;
    per_byte_write_select_n = 4'hf;
  end
endmodule

// File: sync_burst_sram_port_tb_top.sv
`timescale 1ns/10ps
module sync_burst_sram_port_tb_top;
  logic [15:0] word_address;
  logic        cpu_n, ctl_n, stp_n, mcs_n, cs_h, cs_l_n, abw_n, gate_n;
  logic [3:0]  bs_n;
  logic [35:0] dq_in, dq_out;
  logic        dq_oe, sleep_active, core_clk, rst;
  logic        oe_n, pipe_n, count_order_select, sleep_request;
  logic [35:0] mem_m [logic [15:0]];
  int          errors, cmp_count, cycles;

  sbs_master_model i_master (.core_clk(core_clk), .word_address(word_address),
    .cpu_address_strobe_n(cpu_n), .ctrl_address_strobe_n(ctl_n),
    .burst_step_strobe_n(stp_n), .master_chip_select_n(mcs_n), .chip_select_high(cs_h),
    .chip_select_low_n(cs_l_n), .all_bytes_write_n(abw_n), .byte_lane_write_gate_n(gate_n),
    .per_byte_write_select_n(bs_n), .dq_in(dq_in));

  sbs_port i_dut (.core_clk(core_clk), .rst(rst), .word_address(word_address),
    .cpu_address_strobe_n(cpu_n), .ctrl_address_strobe_n(ctl_n),
    .burst_step_strobe_n(stp_n), .master_chip_select_n(mcs_n), .chip_select_high(cs_h),
    .chip_select_low_n(cs_l_n), .all_bytes_write_n(abw_n), .byte_lane_write_gate_n(gate_n),
    .per_byte_write_select_n(bs_n), .output_enable_n(oe_n),
    .single_register_path_select_n(pipe_n), .count_order_select(count_order_select),
    .sleep_request(sleep_request), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .sleep_active(sleep_active));

  // Clock and hang guard
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Word k of a burst under the current count order
  function automatic logic [15:0] baddr(input logic [15:0] a, input int k);
    logic [1:0] lo;
    lo = count_order_select ? a[1:0] ^ k[1:0] : a[1:0] + k[1:0];
    return {a[15:2], lo};
  endfunction

  task automatic idle(input int n);
    repeat (n) i_master.cyc(1, 1, 1, 1, 1, 4'hf, 16'h0, 36'h0);
  endtask

  task automatic deselect();
    i_master.sel(0, 0, 1);
    i_master.cyc(1, 0, 1, 1, 1, 4'hf, 16'h0, 36'h0);
    i_master.sel(0, 1, 0);
    idle(2);
    chk(dq_oe, 0);
  endtask

  task automatic write_burst(input logic [15:0] a, input logic [35:0] d);
    i_master.cyc(1, 0, 1, 0, 1, 4'hf, a, d);
    mem_m[a] = d;
    for (int k = 1; k < 4; k++) begin
      i_master.cyc(1, 1, 0, 0, 1, 4'hf, 16'h0, d + k);
      mem_m[baddr(a, k)] = d + k;
    end
    deselect();
  endtask

  // Lat counts the extra edges of the output register: 1 pipelined, 0 flow-through
  task automatic read_burst(input logic [15:0] a, input int lat);
    i_master.cyc(0, 1, 1, 1, 1, 4'hf, a, 36'h0);
    if (lat == 0) begin
      chk(dq_out, mem_m[a]);
      chk(dq_oe, 1);
    end
    for (int j = 1; j <= 3 + lat; j++) begin
      i_master.cyc(1, 1, 1'(j > 3), 1, 1, 4'hf, 16'h0, 36'h0);
      if (j >= lat) begin
        chk(dq_out, mem_m[baddr(a, j - lat)]);
        chk(dq_oe, 1);
      end
    end
    deselect();
  endtask

  // Start attempt that must leave the lanes undriven
  task automatic watch_off(input logic m_n, input logic h, input logic l_n);
    i_master.sel(m_n, h, l_n);
    i_master.cyc(0, 1, 1, 1, 1, 4'hf, 16'h4a31, 36'h0);
    i_master.sel(0, 1, 0);
    repeat (3) begin
      idle(1);
      chk(dq_oe, 0);
    end
    deselect();
  endtask

  task automatic t_order();
    logic [15:0] a;
    for (int o = 1; o >= 0; o--) begin
      count_order_select = 1'(o);
      idle(3);
      a = o ? 16'h4a31 : 16'h4a36;
      write_burst(a, 36'h5_c0de_0000 + 36'(o << 8));
      read_burst(a, 1);
    end
    count_order_select = 1;
    idle(3);
  endtask

  task automatic t_flow();
    pipe_n = 0;
    idle(3);
    read_burst(16'h4a31, 0);
    pipe_n = 1;
    idle(3);
  endtask

  task automatic t_bytes();
    logic [35:0] m;
    m = 36'h0_07fc_01ff;
    i_master.cyc(1, 0, 1, 1, 0, 4'b1010, 16'h4a32, 36'h1_2345_6789);
    mem_m[16'h4a32] = (mem_m[16'h4a32] & ~m) | (36'h1_2345_6789 & m);
    i_master.cyc(1, 1, 1, 1, 1, 4'h0, 16'h0, 36'hf_ffff_ffff);
    i_master.cyc(1, 1, 1, 1, 0, 4'hf, 16'h0, 36'hf_ffff_ffff);
    deselect();
    read_burst(16'h4a31, 1);
  endtask

  task automatic t_selects();
    watch_off(1, 1, 0);
    watch_off(0, 0, 0);
    watch_off(0, 1, 1);
    oe_n = 1;
    idle(3);
    watch_off(0, 1, 0);
    oe_n = 0;
    idle(3);
  endtask

  task automatic t_sleep();
    sleep_request = 1;
    idle(4);
    chk(sleep_active, 1);
    watch_off(0, 1, 0);
    sleep_request = 0;
    idle(4);
    chk(sleep_active, 0);
    read_burst(16'h4a31, 1);
  endtask

  // Main sequence
  initial begin
    core_clk = 0;
    rst = 1;
    oe_n = 0;
    pipe_n = 1;
    count_order_select = 1;
    sleep_request = 0;
    repeat (4) @(posedge core_clk);
    #1;
    rst = 0;
    idle(3);
    chk(dq_oe, 0);
    t_order();
    t_flow();
    t_bytes();
    t_selects();
    t_sleep();
    tally_and_finish();
  end
endmodule
